// file: sysbus_handshake_pkg.sv
// package: constants for the system bus mastership and handshake block
package sysbus_handshake_pkg;
    localparam int unsigned ADDR_DATA_WIDTH  = 32;
    localparam int unsigned COMMAND_WIDTH    = 5;
    localparam int unsigned CMD_KIND_BIT     = 4;      // top command bit: 0 address, 1 data
    localparam logic        CMD_KIND_ADDRESS = 1'h0;
    localparam logic        CMD_KIND_DATA    = 1'h1;
    localparam logic        ACTIVE_N         = 1'h0;   // handshakes are active low
    localparam logic        INACTIVE_N       = 1'h1;

    // bus ownership states
    typedef enum logic [2:0] {
        ST_MASTER      = 3'b000,
        ST_REL_TURN    = 3'b001,
        ST_SLAVE_ARB   = 3'b010,
        ST_SLAVE_READ  = 3'b011,
        ST_RET_TURN    = 3'b100
    } own_state_t;
endpackage

// file: sysbus_handshake.sv
// system bus mastership, turnaround and command handshake logic (device end)
//
// Notes on behaviour
// - every bus output comes straight from a flip-flop
// - every bus input passes an input flip-flop before use
// - as master, drive both buses and strobe valid when content is valid
// - master after reset; leave only on granted request or issued read
// - agent asks with bus request; device grants by negating owns-bus
// - after arbitrated release with no read pending, return to master once the request ends
// - pending read makes device release on its own, now or later
// - after own release, resume master when next external request ends
// - on release negate owns-bus and float buses for one turnaround cycle
// - on return buses stay undriven one cycle, then device drives them
// - valid strobe means new word on data bus and new command word
// - command accepted only if accept was active before and during strobe
// - read response data accepted at any rate with any gaps
// - top command bit: zero address cycle, one data cycle
// - in slave state with a request waiting, assert own bus request
`timescale 1ns/1ps
module sysbus_handshake
    import sysbus_handshake_pkg::*;
#(
    parameter int unsigned DW = ADDR_DATA_WIDTH,
    parameter int unsigned CW = COMMAND_WIDTH
) (
    input  wire logic          i_ref_clk,
    input  wire logic          i_rst_n,
    // system bus pins
    input  wire logic [DW-1:0] i_sys_addr_data_bus,
    output logic      [DW-1:0] o_sys_addr_data_bus,
    output logic               o_sys_addr_data_bus_oe,
    input  wire logic [CW-1:0] i_sys_command_bus,
    output logic      [CW-1:0] o_sys_command_bus,
    output logic               o_sys_command_bus_oe,
    output logic               o_proc_valid_n,
    input  wire logic          i_agent_valid_n,
    output logic               o_proc_owns_bus_n,
    input  wire logic          i_agent_accept_n,
    input  wire logic          i_agent_bus_request_n,
    output logic               o_proc_bus_request_n,
    // core side: outgoing cycles
    input  wire logic          i_core_valid,
    input  wire logic          i_core_is_data,
    input  wire logic          i_core_is_read,
    input  wire logic          i_core_is_last,
    input  wire logic [CW-2:0] i_core_code,
    input  wire logic [DW-1:0] i_core_word,
    input  wire logic          i_core_release_ok,
    output logic               o_core_ready,
    output logic               o_core_cmd_accepted,
    output logic               o_core_cmd_killed,
    // core side: incoming cycles
    output logic               o_rx_valid,
    output logic               o_rx_is_data,
    output logic [CW-2:0]      o_rx_code,
    output logic [DW-1:0]      o_rx_word,
    input  wire logic          i_rx_request_end,
    output logic               o_is_master
);
    own_state_t     state_r;
    own_state_t     state_nxt;
    logic [DW-1:0]  ad_in_r;
    logic [CW-1:0]  cmd_in_r;
    logic           agent_valid_n_in_r;
    logic           accept_in_r;
    logic           accept_prev_r;
    logic           agent_bus_request_n_in_r;
    logic           read_pending_r;
    logic           write_pending_r;
    logic           strobe_cmd;
    logic           cmd_ok;
    logic           drive;

    // input capture, one flip-flop then a second for the asynchronous far end
    logic [DW-1:0]  ad_meta_r;
    logic [CW-1:0]  cmd_meta_r;
    logic           agent_valid_n_meta_r;
    logic           accept_meta_r;
    logic           agent_bus_request_n_meta_r;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ad_meta_r     <= '0;
            cmd_meta_r    <= '0;
            agent_valid_n_meta_r <= INACTIVE_N;
            accept_meta_r <= INACTIVE_N;
            agent_bus_request_n_meta_r   <= INACTIVE_N;
            ad_in_r       <= '0;
            cmd_in_r      <= '0;
            agent_valid_n_in_r   <= INACTIVE_N;
            accept_in_r   <= INACTIVE_N;
            agent_bus_request_n_in_r     <= INACTIVE_N;
        end else begin
            ad_meta_r     <= i_sys_addr_data_bus;
            cmd_meta_r    <= i_sys_command_bus;
            agent_valid_n_meta_r <= i_agent_valid_n;
            accept_meta_r <= i_agent_accept_n;
            agent_bus_request_n_meta_r   <= i_agent_bus_request_n;
            ad_in_r       <= ad_meta_r;
            cmd_in_r      <= cmd_meta_r;
            agent_valid_n_in_r   <= agent_valid_n_meta_r;
            accept_in_r   <= accept_meta_r;
            agent_bus_request_n_in_r     <= agent_bus_request_n_meta_r;
        end
    end

    // accept history: a command counts only with accept active before and now
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            accept_prev_r <= INACTIVE_N;
        end else begin
            accept_prev_r <= accept_in_r;
        end
    end

    // only address cycles are gated by accept; data follows freely at core rate
    // nothing is taken in the edge that gives the bus away, or the word would go out floated
    assign strobe_cmd = (state_r == ST_MASTER) && (state_nxt == ST_MASTER) && i_core_valid && !i_core_is_data
                        && (agent_bus_request_n_in_r == INACTIVE_N);
    assign cmd_ok     = (accept_prev_r == ACTIVE_N) && (accept_in_r == ACTIVE_N);
    assign drive      = (state_r == ST_MASTER);
    assign o_core_ready = drive && (state_nxt == ST_MASTER) && (agent_bus_request_n_in_r == INACTIVE_N)
                          && (i_core_is_data || cmd_ok);
    assign o_is_master  = drive;

    // pending request bookkeeping, set wins over clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            read_pending_r  <= 1'b0;
            write_pending_r <= 1'b0;
        end else begin
            if (strobe_cmd && cmd_ok && i_core_is_read) begin
                read_pending_r <= 1'b1;
            end else if (state_r == ST_SLAVE_READ && i_rx_request_end) begin
                read_pending_r <= 1'b0;
            end
            // a core cycle waiting while we do not own the bus
            write_pending_r <= i_core_valid && !drive;
        end
    end

    // ownership state machine
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_MASTER: begin
                if (agent_bus_request_n_in_r == ACTIVE_N && i_core_release_ok) begin
                    state_nxt = ST_REL_TURN;
                end else if (read_pending_r && i_core_release_ok) begin
                    state_nxt = ST_REL_TURN;
                end
            end
            ST_REL_TURN: begin
                // bus floats one cycle before the agent may drive
                state_nxt = read_pending_r && (agent_bus_request_n_in_r != ACTIVE_N) ? ST_SLAVE_READ : ST_SLAVE_ARB;
            end
            ST_SLAVE_ARB: begin
                if (agent_bus_request_n_in_r == INACTIVE_N && !read_pending_r) begin
                    state_nxt = ST_RET_TURN;
                end else if (agent_bus_request_n_in_r == INACTIVE_N) begin
                    state_nxt = ST_SLAVE_READ;
                end
            end
            ST_SLAVE_READ: begin
                if (agent_bus_request_n_in_r == ACTIVE_N) begin
                    state_nxt = ST_SLAVE_ARB;
                end else if (i_rx_request_end) begin
                    state_nxt = ST_RET_TURN;
                end
            end
            ST_RET_TURN: begin
                state_nxt = ST_MASTER;
            end
            default: begin
                state_nxt = ST_MASTER;
            end
        endcase
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r <= ST_MASTER;
        end else begin
            state_r <= state_nxt;
        end
    end

    // bus outputs, all registered; enables follow the next ownership state
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sys_addr_data_bus    <= '0;
            o_sys_command_bus      <= '0;
            o_sys_addr_data_bus_oe <= 1'b1;
            o_sys_command_bus_oe   <= 1'b1;
            o_proc_valid_n         <= INACTIVE_N;
            o_proc_owns_bus_n      <= ACTIVE_N;
            o_proc_bus_request_n   <= INACTIVE_N;
        end else begin
            o_sys_addr_data_bus_oe <= (state_nxt == ST_MASTER);
            o_sys_command_bus_oe   <= (state_nxt == ST_MASTER);
            o_proc_owns_bus_n      <= (state_nxt == ST_MASTER) ? ACTIVE_N : INACTIVE_N;
            o_proc_valid_n         <= (drive && o_core_ready && i_core_valid) ? ACTIVE_N : INACTIVE_N;
            if (drive && i_core_valid) begin
                o_sys_addr_data_bus <= i_core_word;
                o_sys_command_bus   <= {i_core_is_data ? CMD_KIND_DATA : CMD_KIND_ADDRESS,
                                        i_core_code};
            end
            // ask only while the bus stays away; not in the edge that takes it back
            o_proc_bus_request_n <= ((state_nxt != ST_MASTER) && write_pending_r) ? ACTIVE_N : INACTIVE_N;
        end
    end

    // command outcome pulses for the core
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_core_cmd_accepted <= 1'b0;
            o_core_cmd_killed   <= 1'b0;
        end else begin
            o_core_cmd_accepted <= strobe_cmd && cmd_ok;
            o_core_cmd_killed   <= strobe_cmd && (accept_prev_r == ACTIVE_N)
                                   && (accept_in_r == INACTIVE_N);
        end
    end

    // incoming cycles: any valid strobe in slave state, at any spacing
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_rx_valid   <= 1'b0;
            o_rx_is_data <= 1'b0;
            o_rx_code    <= '0;
            o_rx_word    <= '0;
        end else begin
            o_rx_valid <= !drive && (agent_valid_n_in_r == ACTIVE_N);
            if (!drive && agent_valid_n_in_r == ACTIVE_N) begin
                o_rx_is_data <= (cmd_in_r[CMD_KIND_BIT] == CMD_KIND_DATA);
                o_rx_code    <= cmd_in_r[CW-2:0];
                o_rx_word    <= ad_in_r;
            end
        end
    end
endmodule

// file: sysbus_handshake_assertions.sv
// checker: port assertions of the bus handshake block
`timescale 1ns/1ps
module sysbus_handshake_assertions
    import sysbus_handshake_pkg::*;
#(parameter int unsigned DW = ADDR_DATA_WIDTH, parameter int unsigned CW = COMMAND_WIDTH) (
    input wire logic          i_ref_clk,
    input wire logic          i_rst_n,
    input wire logic [CW-1:0] o_sys_command_bus,
    input wire logic          o_sys_addr_data_bus_oe,
    input wire logic          o_sys_command_bus_oe,
    input wire logic          o_proc_valid_n,
    input wire logic          i_agent_valid_n,
    input wire logic          o_proc_owns_bus_n,
    input wire logic          i_agent_bus_request_n,
    input wire logic          o_proc_bus_request_n,
    input wire logic          i_core_release_ok,
    input wire logic          o_core_cmd_accepted,
    input wire logic          o_core_cmd_killed,
    input wire logic          o_rx_valid
);
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    // request held while release is allowed; wins the bus in bounded time
    sequence ask_s; (!i_agent_bus_request_n && i_core_release_ok) [*3]; endsequence
    sequence give_up_s; $rose(o_proc_owns_bus_n); endsequence
    sequence strobe_s; !o_proc_valid_n; endsequence
    owner_oe_a: assert property (o_sys_addr_data_bus_oe == !o_proc_owns_bus_n)
        else $error("data enable disagrees with ownership");
    cmd_oe_a: assert property (o_sys_command_bus_oe == o_sys_addr_data_bus_oe)
        else $error("bus enables differ");
    valid_owner_a: assert property (strobe_s |-> !o_proc_owns_bus_n)
        else $error("strobe while not owner");
    release_quiet_a: assert property (give_up_s |-> o_proc_valid_n ##1 o_proc_owns_bus_n)
        else $error("release without quiet turnaround");
    grant_time_a: assert property (ask_s |=> ##[0:5] o_proc_owns_bus_n)
        else $error("request not granted");
    accept_addr_a: assert property (o_core_cmd_accepted |-> strobe_s and o_sys_command_bus[CMD_KIND_BIT] == CMD_KIND_ADDRESS)
        else $error("accept without address strobe");
    kill_only_a: assert property (o_core_cmd_killed |-> !o_core_cmd_accepted && o_proc_valid_n)
        else $error("command both killed and accepted");
    proc_bus_request_n_slave_a: assert property (!o_proc_bus_request_n |-> o_proc_owns_bus_n)
        else $error("bus request while owner");
    rx_seen_a: assert property (!i_agent_valid_n && o_proc_owns_bus_n |-> ##[1:4] o_rx_valid)
        else $error("agent word not received");
endmodule

// file: sysbus_agent_model.sv
// partner: external agent driving the far side of the bus
`timescale 1ns/1ps
module sysbus_agent_model
    import sysbus_handshake_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    input  wire logic        i_owns_n,
    input  wire logic        i_want,
    input  wire logic        i_ready,
    input  wire logic        i_send,
    input  wire logic [31:0] i_word,
    output logic      [31:0] o_ad,
    output logic      [4:0]  o_cmd,
    output logic             o_valid_n,
    output logic             o_accept_n,
    output logic             o_req_n
);
    logic turn_r;
    // drive only after one float cycle; undriven lines toggle, not hold
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            turn_r <= 1'b0;
            o_ad <= 32'h0;
            o_cmd <= 5'h0;
            o_valid_n <= 1'b1;
            o_accept_n <= 1'b1;
            o_req_n <= 1'b1;
        end else begin
            turn_r <= i_owns_n;
            o_req_n <= !i_want;
            o_accept_n <= !i_ready;
            if (turn_r && i_owns_n && i_send) begin
                o_valid_n <= 1'b0;
                o_ad <= i_word;
                o_cmd <= {CMD_KIND_DATA, i_word[3:0]};
            end else begin
                o_valid_n <= 1'b1;
                o_ad <= ~o_ad;
                o_cmd <= ~o_cmd;
            end
        end
    end
endmodule

// file: test_system_bus_mastership_handshake.sv
// testbench: core-side stimulus and agent model around the handshake block
`timescale 1ns/1ps
module test_system_bus_mastership_handshake;
    import sysbus_handshake_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, want = 1'b0, rdy = 1'b1, send = 1'b0, cv = 1'b0, cd = 1'b0, cr = 1'b0;
    logic rel_ok = 1'b0, rend = 1'b0;
    logic [3:0] cc = 4'h0;
    logic [31:0] cw = 32'h0, aw = 32'h0;
    logic [15:0] lfsr = 16'h5132;
    wire logic [31:0] ad_i, ad_o, rx_w;
    wire logic [4:0] cmd_i, cmd_o;
    wire logic [3:0] rx_c;
    wire logic ad_oe, cmd_oe, pv_n, av_n, own_n, acc_n, req_n, proc_bus_request_n_n, c_rdy, c_acc, c_kill, rx_v, rx_d, is_m;
    int n_mismatch = 0, cmp_count = 0;
    always #4 clk = ~clk;
    sysbus_handshake uut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_sys_addr_data_bus(ad_i), .o_sys_addr_data_bus(ad_o),
        .o_sys_addr_data_bus_oe(ad_oe), .i_sys_command_bus(cmd_i), .o_sys_command_bus(cmd_o),
        .o_sys_command_bus_oe(cmd_oe), .o_proc_valid_n(pv_n), .i_agent_valid_n(av_n), .o_proc_owns_bus_n(own_n),
        .i_agent_accept_n(acc_n), .i_agent_bus_request_n(req_n), .o_proc_bus_request_n(proc_bus_request_n_n),
        .i_core_valid(cv), .i_core_is_data(cd), .i_core_is_read(cr), .i_core_is_last(1'b0), .i_core_code(cc),
        .i_core_word(cw), .i_core_release_ok(rel_ok), .o_core_ready(c_rdy), .o_core_cmd_accepted(c_acc),
        .o_core_cmd_killed(c_kill), .o_rx_valid(rx_v), .o_rx_is_data(rx_d), .o_rx_code(rx_c), .o_rx_word(rx_w),
        .i_rx_request_end(rend), .o_is_master(is_m));
    sysbus_agent_model agent (.i_ref_clk(clk), .i_rst_n(rst_n), .i_owns_n(own_n), .i_want(want), .i_ready(rdy),
        .i_send(send), .i_word(aw), .o_ad(ad_i), .o_cmd(cmd_i), .o_valid_n(av_n), .o_accept_n(acc_n), .o_req_n(req_n));
    function automatic logic [15:0] step(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction
    function automatic logic [4:0] exp_cmd(input logic d, input logic [3:0] c);
        return {d ? CMD_KIND_DATA : CMD_KIND_ADDRESS, c};
    endfunction
    task automatic chk(input bit ok, input string m);
        cmp_count++;
        if (!ok) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, m);
        end
    endtask
    task automatic stop_test;
        $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // bounded wait on ownership; a hang shows as a failed compare
    task automatic wait_own(input logic v, input string m);
        for (int n = 0; n < 40 && own_n !== v; n++) @(negedge clk);
        chk(own_n === v, m);
    endtask
    // one core cycle; a kill drops agent ready three edges ahead (agent flop plus two input flops)
    task automatic issue(input logic d, input logic r, input logic kill);
        lfsr = step(lfsr);
        @(posedge clk);
        if (kill) begin
            rdy <= 1'b0;
            repeat (3) @(posedge clk);
        end
        {cv, cd, cr, cc, cw} <= {1'b1, d, r, lfsr[3:0], lfsr, step(lfsr)};
        @(negedge clk);
        for (int n = 0; n < 40 && !kill && c_rdy !== 1'b1; n++) @(negedge clk);
        @(posedge clk);
        cv <= 1'b0;
        @(negedge clk);
        chk(pv_n === kill && (kill || (ad_o === cw && cmd_o === exp_cmd(d, cc))), "strobed word");
        for (int n = 0; n < 6 && !d && c_acc !== 1'b1 && c_kill !== 1'b1; n++) @(negedge clk);
        if (!d) chk(c_kill === kill && c_acc === !kill, "accept or kill");
    endtask
    // agent sends one data word after a gap; core must see it whatever the gap
    task automatic rx(input int gap);
        lfsr = step(lfsr);
        aw = {step(lfsr), lfsr};
        repeat (gap + 1) @(posedge clk);
        send <= 1'b1;
        @(posedge clk);
        send <= 1'b0;
        @(negedge clk);
        for (int n = 0; n < 8 && rx_v !== 1'b1; n++) @(negedge clk);
        chk(rx_v === 1'b1 && rx_w === aw && rx_d === CMD_KIND_DATA && rx_c === aw[3:0], "received word");
    endtask
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        chk(own_n === 1'b0 && ad_oe === 1'b1 && cmd_oe === 1'b1 && pv_n === 1'b1 && is_m === 1'b1, "reset owner");
        $display("test reset done");
        for (int i = 0; i < 6; i++) issue(i[0], 1'b0, 1'b0);
        issue(1'b0, 1'b0, 1'b1);
        @(posedge clk);
        rdy <= 1'b1;
        repeat (4) @(posedge clk);
        $display("test commands done");
        rel_ok <= 1'b1;
        want <= 1'b1;
        wait_own(1'b1, "release on request");
        chk(ad_oe === 1'b0 && cmd_oe === 1'b0 && c_rdy === 1'b0, "floated, refusing");
        @(posedge clk);
        cv <= 1'b1;
        for (int i = 0; i < 3; i++) rx(i * 3);
        chk(proc_bus_request_n_n === 1'b0, "asks bus back");
        @(posedge clk);
        {cv, rend, want, rel_ok} <= 4'b0100;
        @(posedge clk);
        rend <= 1'b0;
        wait_own(1'b0, "return after request");
        chk(ad_oe === 1'b1, "drives again");
        $display("test arbitration done");
        issue(1'b0, 1'b1, 1'b0);
        repeat (5) @(negedge clk);
        chk(own_n === 1'b0, "held while not allowed");
        @(posedge clk);
        rel_ok <= 1'b1;
        wait_own(1'b1, "release after read");
        for (int i = 0; i < 3; i++) rx(i * 5);
        @(posedge clk);
        rend <= 1'b1;
        @(posedge clk);
        rend <= 1'b0;
        wait_own(1'b0, "resume after response");
        $display("test read release done");
        stop_test;
    end
    initial begin
        repeat (5000) @(posedge clk);
        n_mismatch++;
        stop_test;
    end
endmodule
bind sysbus_handshake sysbus_handshake_assertions #(.DW(DW), .CW(CW)) chk_i (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .o_sys_command_bus(o_sys_command_bus), .o_sys_addr_data_bus_oe(o_sys_addr_data_bus_oe),
    .o_sys_command_bus_oe(o_sys_command_bus_oe), .o_proc_valid_n(o_proc_valid_n), .i_agent_valid_n(i_agent_valid_n),
    .o_proc_owns_bus_n(o_proc_owns_bus_n), .i_agent_bus_request_n(i_agent_bus_request_n),
    .o_proc_bus_request_n(o_proc_bus_request_n), .i_core_release_ok(i_core_release_ok),
    .o_core_cmd_accepted(o_core_cmd_accepted), .o_core_cmd_killed(o_core_cmd_killed), .o_rx_valid(o_rx_valid));
